// ==== src/tag_gate.sv ====
// Purpose: zero a multichannel sample stream in a window set by a trigger
// Assumes: one sample per accepted input beat, wishbone classic registers
// Notes: gain is cos^2 shaped; ramp index follows a bresenham stepper
`timescale 1ns/100ps
module tag_gate
    import tag_pkg::*;
#(
    parameter int NCH = 4,
    parameter int W = 16,
    parameter int DMAX = 64
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [NCH*W-1:0] in_data_i,
    input wire logic in_trig_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [NCH*W-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic gate_o,
    output logic rec_valid_o,
    output logic [31:0] rec_time_o
);
    localparam int DW = $clog2(DMAX);

    ////////////////////////////////////////////////////////////////////
    // registers
    logic [TAG_CTRL_W-1:0] ctrl;
    logic [15:0] onset;
    logic [15:0] offset;
    logic [15:0] gate_ramp_time;
    tag_state_t state;
    logic [3:0] idx;
    logic [31:0] tstamp;

    // byte-lane merge for partial writes
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = old;
        if (s[0]) merge16[7:0] = d[7:0];
        if (s[1]) merge16[15:8] = d[15:8];
    endfunction
    wire wb_req = cyc_i && stb_i && !ack_o;
    // single-wait-state ack, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= wb_req;
        end
    end
    // writes; onset and offset live-updatable, take effect next sample
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= TAG_CTRL_RST;
            onset <= TAG_ONSET_RST;
            offset <= TAG_OFFSET_RST;
            gate_ramp_time <= TAG_RAMP_RST;
        end else if (wb_req && we_i) begin
            if (adr_i == TAG_REG_CTRL) begin
                if (sel_i[0]) begin
                    ctrl <= dat_i[TAG_CTRL_W-1:0];
                end
            end else if (adr_i == TAG_REG_ONSET) begin
                onset <= merge16(onset, dat_i, sel_i);
            end else if (adr_i == TAG_REG_OFFSET) begin
                offset <= merge16(offset, dat_i, sel_i);
            end else if (adr_i == TAG_REG_RAMP) begin
                gate_ramp_time <= merge16(gate_ramp_time, dat_i, sel_i);
            end
        end
    end
    // reads; unmapped offsets return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (wb_req && !we_i) begin
            if (adr_i == TAG_REG_CTRL) begin
                dat_o <= {{(32-TAG_CTRL_W){1'b0}}, ctrl};
            end else if (adr_i == TAG_REG_ONSET) begin
                dat_o <= {16'h0000, onset};
            end else if (adr_i == TAG_REG_OFFSET) begin
                dat_o <= {16'h0000, offset};
            end else if (adr_i == TAG_REG_RAMP) begin
                dat_o <= {16'h0000, gate_ramp_time};
            end else if (adr_i == TAG_REG_STATUS) begin
                dat_o <= {25'h0, idx, state};
            end else if (adr_i == TAG_REG_TSTAMP) begin
                dat_o <= tstamp;
            end else begin
                dat_o <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // input delay line
    logic [NCH*W-1:0] dline [DMAX];
    logic [DW-1:0] wptr;
    logic [DW-1:0] dly;
    logic [NCH*W-1:0] delayed;
    wire take = in_valid_i && in_ready_o;
    wire onset_neg = onset[15];
    wire [15:0] onset_mag = -onset;
    // negative onset becomes a delay, clamped to one less than the line length (DMAX - 1)
    always_comb begin
        if (!onset_neg) begin
            dly = '0;
        end else if (onset_mag > 16'(DMAX - 1)) begin
            dly = DW'(DMAX - 1);
        end else begin
            dly = onset_mag[DW-1:0];
        end
        delayed = (dly == '0) ? in_data_i : dline[wptr - dly];
    end

    always_ff @(posedge clk_i) begin
        if (take) begin
            dline[wptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wptr <= '0;
            tstamp <= 32'h0000_0000;
        end else if (take) begin
            wptr <= wptr + 1'b1;
            tstamp <= tstamp + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // trigger detection and window bounds
    logic trig_prev;
    logic [15:0] cnt;
    wire trig = in_trig_i ^ ctrl[TAG_CTRL_INVERT];
    wire trig_edge = take && trig && !trig_prev;
    // with the input delayed, the gate opens at trigger time itself
    wire [15:0] start = onset_neg ? 16'h0000 : onset;
    wire [15:0] stop = ctrl[TAG_CTRL_OFF_REL] ?
                       16'(start + offset) :
                       16'(offset + 16'(dly));
    wire hard = gate_ramp_time < TAG_RAMP_MIN;
    // with a square edge, a zero start gates the trigger beat itself, before the fsm moves
    wire at_start = (state == TAG_WAIT) ? cnt >= start :
                    state == TAG_IDLE && trig_edge && start == 16'h0000;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_prev <= 1'b0;
        end else if (take) begin
            trig_prev <= trig;
        end
    end
    // bresenham step of the shape index: ramp_time samples per 15 steps
    logic [15:0] acc;
    logic [15:0] next_acc;
    logic [3:0] next_step;
    always_comb begin
        next_acc = acc + 16'(TAG_LUT_LAST);
        next_step = 4'h0;
        for (int i = 0; i < 4; i++) begin
            if (!hard && next_acc >= gate_ramp_time) begin
                next_acc = next_acc - gate_ramp_time;
                next_step = next_step + 4'h1;
            end
        end
    end
    wire [4:0] up_sum = {1'b0, idx} + {1'b0, next_step};
    wire [3:0] idx_up = up_sum[4] ? TAG_LUT_LAST : up_sum[3:0];
    wire [3:0] idx_dn = (next_step > idx) ? 4'h0 : idx - next_step;

    ////////////////////////////////////////////////////////////////////
    // gate sequencer, advances once per accepted sample
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= TAG_IDLE;
            cnt <= 16'h0000;
            idx <= 4'h0;
            acc <= 16'h0000;
        end else if (take) begin
            if (cnt != 16'hffff) cnt <= cnt + 16'h0001;
            case (state)
                TAG_IDLE: begin
                    if (trig_edge) begin
                        cnt <= 16'h0001;
                        state <= TAG_WAIT;
                    end
                end
                TAG_WAIT: begin
                    // starts counted from the trigger sample as zero
                    if (cnt >= start) begin
                        acc <= 16'h0000;
                        idx <= 4'h0;
                        state <= hard ? TAG_SHUT : TAG_FALL;
                    end
                end
                TAG_FALL: begin
                    acc <= next_acc;
                    idx <= idx_up;
                    if (idx == TAG_LUT_LAST) begin
                        state <= TAG_SHUT;
                    end
                end
                TAG_SHUT: begin
                    if (cnt >= stop) begin
                        acc <= 16'h0000;
                        idx <= TAG_LUT_LAST;
                        state <= hard ? TAG_IDLE : TAG_RISE;
                    end
                end
                TAG_RISE: begin
                    acc <= next_acc;
                    idx <= idx_dn;
                    if (idx == 4'h0) begin
                        state <= TAG_IDLE;
                    end
                end
                default: begin
                    state <= TAG_IDLE;
                end
            endcase
        end
    end
    // gain for the current sample; a square edge reopens at the stop beat
    logic [15:0] gain;
    always_comb begin
        if (state == TAG_SHUT && !(hard && cnt >= stop)) begin
            gain = TAG_GAIN_ZERO;
        end else if (hard && at_start) begin
            gain = TAG_GAIN_ZERO;
        end else if (state == TAG_FALL || state == TAG_RISE) begin
            gain = TAG_LUT[idx];
        end else begin
            gain = TAG_GAIN_FULL;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // per-channel scaling, one shared gain
    logic [NCH*W-1:0] gated;
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_ch
            wire signed [W-1:0] s = delayed[ch*W +: W];
            wire signed [W+16:0] p = s * $signed({1'b0, gain});
            // full gain passes the word untouched to avoid a 1-lsb loss
            assign gated[ch*W +: W] = (gain == TAG_GAIN_FULL) ? s :
                                      p[W+TAG_GAIN_FRAC-1:TAG_GAIN_FRAC];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // two-entry output buffer, head sits in buf0
    logic [NCH*W-1:0] buf0;
    logic [NCH*W-1:0] buf1;
    logic [1:0] fill;
    logic [1:0] next_fill;
    wire pop = out_valid_o && out_ready_i;
    always_comb begin
        next_fill = fill;
        if (take && !pop) begin
            next_fill = fill + 2'd1;
        end else if (pop && !take) begin
            next_fill = fill - 2'd1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fill <= 2'd0;
            in_ready_o <= 1'b1;
            out_valid_o <= 1'b0;
        end else begin
            fill <= next_fill;
            in_ready_o <= next_fill != 2'd2; // stall reaches the source
            out_valid_o <= next_fill != 2'd0;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf0 <= '0;
            buf1 <= '0;
        end else begin
            if (pop) begin
                buf0 <= (fill == 2'd2) ? buf1 : gated;
            end else if (take && fill == 2'd0) begin
                buf0 <= gated;
            end
            if (take && (fill == 2'd2 || (fill == 2'd1 && !pop))) begin
                buf1 <= gated;
            end
        end
    end
    assign out_data_o = buf0;

    ////////////////////////////////////////////////////////////////////
    // gate export and artifact records
    wire gate_on = state inside {TAG_FALL, TAG_SHUT, TAG_RISE};
    wire gate_start = take && state == TAG_WAIT && cnt >= start;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gate_o <= 1'b0;
            rec_valid_o <= 1'b0;
            rec_time_o <= 32'h0000_0000;
        end else begin
            gate_o <= ctrl[TAG_CTRL_EXPORT] && gate_on;
            rec_valid_o <= ctrl[TAG_CTRL_STORE] && gate_start;
            if (gate_start) begin
                rec_time_o <= tstamp;
            end
        end
    end
endmodule

// ==== src/tag_pkg.sv ====
// Purpose: shared constants for the triggered artifact gate
// Assumes: classic wishbone register bus, 32-bit data, byte addresses
// Notes: gain values are unsigned q1.15, full pass is just below 1.0
package tag_pkg;
    // register byte offsets
    localparam logic [7:0] TAG_REG_CTRL = 8'h00;
    localparam logic [7:0] TAG_REG_ONSET = 8'h04;
    localparam logic [7:0] TAG_REG_OFFSET = 8'h08;
    localparam logic [7:0] TAG_REG_RAMP = 8'h0c;
    localparam logic [7:0] TAG_REG_STATUS = 8'h10;
    localparam logic [7:0] TAG_REG_TSTAMP = 8'h14;
    // control field positions
    localparam int TAG_CTRL_INVERT = 0;
    localparam int TAG_CTRL_OFF_REL = 1;
    localparam int TAG_CTRL_EXPORT = 2;
    localparam int TAG_CTRL_STORE = 3;
    localparam int TAG_CTRL_W = 4;
    // reset values
    localparam logic [3:0] TAG_CTRL_RST = 4'h0;
    localparam logic [15:0] TAG_ONSET_RST = 16'h0000;
    localparam logic [15:0] TAG_OFFSET_RST = 16'h0010;
    localparam logic [15:0] TAG_RAMP_RST = 16'h0000;
    // ramps shorter than this use a square edge
    localparam logic [15:0] TAG_RAMP_MIN = 16'h0004;
    // shape table: 16 steps of cos^2 from 1.0 down to 0.1
    localparam int TAG_LUT_N = 16;
    localparam logic [3:0] TAG_LUT_LAST = 4'hf;
    localparam logic [15:0] TAG_GAIN_FULL = 16'h7fff;
    localparam logic [15:0] TAG_GAIN_ZERO = 16'h0000;
    localparam logic [15:0] TAG_LUT [TAG_LUT_N] = '{
        16'h7fff, 16'h7f1d, 16'h7c7c, 16'h782d,
        16'h7250, 16'h6b11, 16'h629f, 16'h5938,
        16'h4f21, 16'h449d, 16'h39f5, 16'h2f78,
        16'h2575, 16'h1c30, 16'h13ea, 16'h0cd3
    };
    localparam int TAG_GAIN_FRAC = 15;
    // gate sequencer states
    typedef enum logic [2:0] {
        TAG_IDLE = 3'b000,
        TAG_WAIT = 3'b001,
        TAG_FALL = 3'b010,
        TAG_SHUT = 3'b011,
        TAG_RISE = 3'b100
    } tag_state_t;
endpackage

// ==== test/tag_gate_sva.sv ====
// Purpose: port-level checks for the artifact gate
// Assumes: one clock domain, synchronous reset active high
// Notes: buffer checks rely on the two-entry output buffer
`timescale 1ns/100ps
module tag_gate_chk #(
    parameter int NCH = 4,
    parameter int W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic in_valid_i,
    input wire logic in_ready_o,
    input wire logic [NCH*W-1:0] out_data_o,
    input wire logic out_valid_o,
    input wire logic out_ready_i,
    input wire logic rec_valid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////
    // bus side: one answer per take, one cycle later
    property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle after");
    property p_ack1; ack_o |=> !ack_o; endproperty
    a_ack1: assert property (p_ack1) else $error("ack longer than a pulse");
    property p_unmap;
        cyc_i && stb_i && !ack_o && !we_i && adr_i >= 8'h18 |=> dat_o == 0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    ////////////////////////////////////////////////////////////////////////
    // stream side: a stalled head must not move or vanish
    property p_hold;
        out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o);
    endproperty
    a_hold: assert property (p_hold) else $error("stalled word changed");
    property p_fill;
        out_valid_o && !out_ready_i && in_valid_i && in_ready_o
            |=> !in_ready_o;
    endproperty
    a_fill: assert property (p_fill) else $error("full buffer still ready");
    property p_first; !out_valid_o && in_valid_i && in_ready_o |=> out_valid_o;
    endproperty
    a_first: assert property (p_first) else $error("word late into empty");
    property p_full; !in_ready_o |-> out_valid_o; endproperty
    a_full: assert property (p_full) else $error("not ready while empty");
    property p_rec; rec_valid_o |=> !rec_valid_o; endproperty
    a_rec: assert property (p_rec) else $error("record not a pulse");
endmodule
bind tag_gate tag_gate_chk #(.NCH(NCH), .W(W)) u_chk (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .dat_o(dat_o), .ack_o(ack_o), .in_valid_i(in_valid_i),
    .in_ready_o(in_ready_o), .out_data_o(out_data_o),
    .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
    .rec_valid_o(rec_valid_o));

// ==== test/tag_sink.sv ====
// Purpose: downstream consumer that collects gated words
// Assumes: valid/ready handshake taken at the rising edge
// Notes: idles one cycle in four so the buffer sees backpressure
`timescale 1ns/100ps
module tag_sink #(
    parameter int DW = 64
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [DW-1:0] data_i,
    input wire logic valid_i,
    input wire logic stall_i,
    output logic ready_o = 1'b0
);
    logic [DW-1:0] got [$];
    logic [1:0] ph = 2'h0;
    // slow, and fully stalled on command from the bench
    always @(posedge clk_i) begin
        ph <= rst_i ? 2'h0 : ph + 2'h1;
        ready_o <= !rst_i && !stall_i && ph != 2'h3;
    end
    // a word counts only where both sides agree
    always @(posedge clk_i) begin
        if (!rst_i && valid_i === 1'b1 && ready_o === 1'b1)
            got.push_back(data_i);
    end
endmodule

// ==== test/tb.sv ====
// Purpose: self-checking bench for the artifact gate
// Assumes: wishbone classic master, sink model downstream
// Notes: short runs keep each gate window well inside a run
`timescale 1ns/100ps
module tb;
    import tag_pkg::*;
    localparam int DW = 64;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, stall = 0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0, dat_o, rec_time_o, q, rt, rt1;
    logic ack_o, in_ready_o, out_valid_o, out_ready_i, gate_o, rec_valid_o;
    logic in_trig_i = 0, in_valid_i = 0;
    logic [DW-1:0] in_data_i = '0, out_data_o;
    int failures = 0, check_count = 0, cycles = 0, gate_cnt, rec_cnt;
    tag_gate #(.NCH(4), .W(16), .DMAX(64)) DUT (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .in_data_i(in_data_i), .in_trig_i(in_trig_i),
        .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
        .out_data_o(out_data_o), .out_valid_o(out_valid_o),
        .out_ready_i(out_ready_i), .gate_o(gate_o),
        .rec_valid_o(rec_valid_o), .rec_time_o(rec_time_o));
    tag_sink #(.DW(DW)) u_sink (.clk_i(clk_i), .rst_i(rst_i),
        .data_i(out_data_o), .valid_i(out_valid_o), .stall_i(stall),
        .ready_o(out_ready_i));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    // watchdog plus gate and record monitors
    always @(posedge clk_i) begin
        cycles++;
        if (gate_o === 1'b1) gate_cnt++;
        if (rec_valid_o === 1'b1) begin
            rec_cnt++;
            rt = rec_time_o;
        end
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("failures %0d checks %0d", failures, check_count);
        if (failures == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        check_count++;
        if (ok !== 1'b1) begin
            failures++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    // each channel distinct and positive so scaling is visible
    function automatic logic [DW-1:0] pat(input int i);
        for (int c = 0; c < 4; c++) pat[c*16 +: 16] = 16'(256 + i * 4 + c);
    endfunction
    ////////////////////////////////////////////////////////////////////////
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 0;
        stb_i <= 0;
        dat_i <= ~d;
        @(posedge clk_i);
    endtask
    task automatic cfg(input logic [3:0] c, input logic [15:0] on,
                       input logic [15:0] off, input logic [15:0] r);
        wb(1, TAG_REG_CTRL, {28'h0, c});
        wb(1, TAG_REG_ONSET, {16'h0, on});
        wb(1, TAG_REG_OFFSET, {16'h0, off});
        wb(1, TAG_REG_RAMP, {16'h0, r});
        gate_cnt = 0;
        rec_cnt = 0;
    endtask
    // n beats, trigger active for three beats from beat t
    task automatic run(input int n, input int t, input logic idle);
        u_sink.got.delete();
        for (int i = 0; i < n; i++) begin
            in_data_i <= pat(i);
            in_trig_i <= (i >= t && i < t + 3) ? !idle : idle;
            in_valid_i <= 1;
            do @(posedge clk_i); while (in_ready_o !== 1'b1);
        end
        in_valid_i <= 0;
        in_data_i <= ~pat(n - 1);
        for (int w = 0; w < 300 && u_sink.got.size() < n; w++)
            @(posedge clk_i);
        chk(u_sink.got.size() == n, "word count");
    endtask
    // zero where count from trigger is in [s,e), else delayed input
    task automatic win(input int n, input int t, input int s, input int e,
                       input int d);
        logic [DW-1:0] x;
        for (int k = d; k < n; k++) begin
            x = (k - t >= s && k - t < e) ? '0 : pat(k - d);
            chk(u_sink.got[k] === x, "gated word");
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [7:0] a [7] = '{TAG_REG_CTRL, TAG_REG_ONSET, TAG_REG_OFFSET,
            TAG_REG_RAMP, TAG_REG_STATUS, TAG_REG_TSTAMP, 8'h20};
        logic [15:0] e [7] = '{16'h0, TAG_ONSET_RST, TAG_OFFSET_RST,
            TAG_RAMP_RST, 16'h0, 16'h0, 16'h0};
        wb(1, 8'h20, 32'h0000_ffff);
        for (int i = 0; i < 7; i++) begin
            wb(0, a[i], 32'h0);
            chk(q === {16'h0, e[i]}, "reset or unmapped read");
        end
        wb(1, TAG_REG_ONSET, 32'h0000_1234);
        wb(0, TAG_REG_ONSET, 32'h0);
        chk(q[15:0] === 16'h1234, "onset readback");
    endtask
    task automatic t_default();
        cfg(4'hc, 16'd2, 16'd5, 16'd0);
        stall <= 1;
        fork
            run(24, 4, 0);
            begin
                repeat (8) @(posedge clk_i);
                chk(in_ready_o === 1'b0, "buffer never refused");
                stall <= 0;
            end
        join
        win(24, 4, 2, 5, 0);
        chk(gate_cnt >= 3, "gate not exported");
        chk(rec_cnt == 1, "record count");
        rt1 = rt;
    endtask
    task automatic t_rel();
        cfg(4'h2, 16'd2, 16'd3, 16'd0);
        run(24, 4, 0);
        win(24, 4, 2, 5, 0);
        chk(gate_cnt == 0 && rec_cnt == 0, "gate out while off");
    endtask
    task automatic t_neg();
        cfg(4'h0, 16'hfffd, 16'd4, 16'd0);
        run(24, 8, 0);
        win(24, 8, 0, 7, 3);
    endtask
    task automatic t_ramp();
        int p;
        logic [15:0] v;
        logic [DW-1:0] x;
        cfg(4'h8, 16'd1, 16'd30, 16'd8);
        run(80, 4, 0);
        p = 0;
        // channel 0 only; cos2 barely moves on its first step
        for (int k = 4; k < 20; k++) begin
            v = u_sink.got[k][15:0];
            x = pat(k);
            if (p == 0 && v !== x[15:0] && v !== 16'h0) begin
                p = 1;
                chk(50 * v > 49 * x[15:0], "first step not cos2");
            end
        end
        chk(p == 1, "edge not shaped");
        // ramp of 8 starts at beat 6, so beat 14 sits near 10% gain
        v = u_sink.got[14][15:0];
        x = pat(14);
        chk(v !== 16'h0 && 9 * v < x[15:0], "not 90% down");
        chk(u_sink.got[17] === '0, "not shut after ramp");
        chk(u_sink.got[79] === pat(79), "not reopened");
        // 18 + 24 + 24 beats after the first record, then 5 into this run
        chk(rec_cnt == 1 && rt - rt1 == 32'd71, "record time");
    endtask
    task automatic t_inv();
        cfg(4'h1, 16'd0, 16'd2, 16'd0);
        run(24, 5, 1);
        win(24, 5, 0, 2, 0);
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        t_regs();
        t_default();
        t_rel();
        t_neg();
        t_ramp();
        t_inv();
        tally_and_finish();
    end
endmodule
